// >>> src/posm_pkg.sv
// Purpose: Shared constants for the pin output source multiplexer.
// Assumes: 32-bit AXI4-Lite register bus, eight port D pins.
// Notes:   Offsets are byte addresses; every register is one aligned word.
package posm_pkg;

    localparam int          POSM_PINS        = 8;
    localparam int          POSM_CODES       = 32;
    localparam int          POSM_SEL_W       = 5;
    localparam int          POSM_ADDR_W      = 8;

    // Register byte offsets
    localparam logic [7:0]  POSM_OFS_LATCH   = 8'h00;
    localparam logic [7:0]  POSM_OFS_PINS    = 8'h04;
    localparam logic [7:0]  POSM_OFS_DIR     = 8'h08;
    localparam logic [7:0]  POSM_OFS_SEL     = 8'h20;
    localparam logic [7:0]  POSM_OFS_SEL_END = 8'h3C;

    // Field positions
    localparam int          POSM_SEL_LSB     = 0;
    localparam int          POSM_SEL_MSB     = 4;
    localparam int          POSM_IDX_LSB     = 2;
    localparam int          POSM_IDX_MSB     = 4;

    // Reset values
    localparam logic [7:0]  POSM_LATCH_RST   = 8'h00;
    localparam logic [7:0]  POSM_DIR_RST     = 8'hFF;
    localparam logic [4:0]  POSM_SEL_RST     = 5'h00;

    // Selection codes
    localparam logic [4:0]  POSM_CODE_LATCH  = 5'h00;
    localparam logic [4:0]  POSM_CODE_NCO    = 5'h03;
    localparam logic [4:0]  POSM_CODE_CLC1   = 5'h04;
    localparam logic [4:0]  POSM_CODE_CLC2   = 5'h05;
    localparam logic [4:0]  POSM_CODE_CLC3   = 5'h06;
    localparam logic [4:0]  POSM_CODE_CLC4   = 5'h07;
    localparam logic [4:0]  POSM_CODE_COGA   = 5'h08;
    localparam logic [4:0]  POSM_CODE_COGB   = 5'h09;
    localparam logic [4:0]  POSM_CODE_COGC   = 5'h0A;
    localparam logic [4:0]  POSM_CODE_COGD   = 5'h0B;
    localparam logic [4:0]  POSM_CODE_CAPTURE_COMPARE_ONE_OUTPUT   = 5'h0C;
    localparam logic [4:0]  POSM_CODE_CAPTURE_COMPARE_TWO_OUTPUT   = 5'h0D;
    localparam logic [4:0]  POSM_CODE_PWM3   = 5'h0E;
    localparam logic [4:0]  POSM_CODE_PWM4   = 5'h0F;
    localparam logic [4:0]  POSM_CODE_SCK    = 5'h10;
    localparam logic [4:0]  POSM_CODE_SDO    = 5'h11;
    localparam logic [4:0]  POSM_CODE_UTXCK  = 5'h14;
    localparam logic [4:0]  POSM_CODE_UDT    = 5'h15;
    localparam logic [4:0]  POSM_CODE_CMP1   = 5'h16;
    localparam logic [4:0]  POSM_CODE_CMP2   = 5'h17;

    // Codes that reach port D: latch, NCO, CLC3/4, COG B-D, PWM4, comparator 1
    localparam logic [31:0] POSM_PORT_D_PIN_REGISTER_SUPPORT = 32'h0040_8EC9;
    // Codes whose peripheral takes over the pin driver enable
    localparam logic [31:0] POSM_DIR_OVERRIDE  = 32'h0033_0F00;

    localparam logic [1:0]  POSM_RESP_OKAY   = 2'b00;
    localparam logic [1:0]  POSM_RESP_SLVERR = 2'b10;

endpackage : posm_pkg

// >>> src/posm_src_mux.sv
// Purpose: One pin's output source selector and driver enable.
// Assumes: Source bit 0 carries the pin's own latch bit.
// Notes:   Purely combinational between selection code and pin.
`timescale 1ns/1ps
module posm_src_mux #(
    parameter logic [31:0] SUPPORT  = posm_pkg::POSM_PORT_D_PIN_REGISTER_SUPPORT,
    parameter logic [31:0] OVERRIDE = posm_pkg::POSM_DIR_OVERRIDE
) (
    input  wire logic [4:0]  sel,
    input  wire logic [31:0] sources,
    input  wire logic        dir_is_input,
    output logic             pin_o,
    output logic             pin_oe
);

    logic code_ok;
    logic force_drive;

    // Codes that do not reach this port, and reserved codes, drive zero
    assign code_ok     = SUPPORT[sel];
    assign pin_o       = code_ok ? sources[sel] : 1'b0;
    assign force_drive = code_ok & OVERRIDE[sel];
    // Peripheral takes the driver regardless of the direction bit
    assign pin_oe      = force_drive ? 1'b1 : ~dir_is_input;

endmodule : posm_src_mux

// >>> src/posm_sync2.sv
// Purpose: Two-flop synchroniser for asynchronous pin levels.
// Assumes: Inputs arrive from outside the aclk domain.
// Notes:   First stage is read only by the second stage.
`timescale 1ns/1ps
module posm_sync2 #(
    parameter int W = 8
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else if (ce)
        begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule : posm_sync2

// >>> src/posm_top.sv
// Purpose: Port D output latch and per-pin output source selection.
// Assumes: AXI4-Lite slave on aclk; peripheral outputs are on aclk.
// Notes:   Pin outputs are combinational from registers and sources.
//
// Notes on behaviour
// - Port D output latch is eight read/write bits, unknown at power-on; this design clears it to 00 on aresetn.
// - Select registers store only bits 4-0; bits 7-5 read zero.
// - Each pin is driven by the source its own code picks.
// - Code 0 latch, 3 oscillator, 4-7 logic cells, 8-11 generator phases.
// - Codes 12-15 capture/PWM, 16-17 serial, 20-21 USART, 22-23 comparators.
// - Reserved codes drive a constant zero on the pin.
// - Only codes supported on this port reach the pin.
// - Some peripherals override the direction and force the driver on.
// - Selection codes clear to zero at power-on reset.
// - Pin register writes go to the latch; reads return pin levels.
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module posm_top #(
    parameter int          PINS     = posm_pkg::POSM_PINS,
    parameter logic [31:0] SUPPORT  = posm_pkg::POSM_PORT_D_PIN_REGISTER_SUPPORT,
    parameter logic [31:0] OVERRIDE = posm_pkg::POSM_DIR_OVERRIDE
) (
    input  wire logic            aclk,
    input  wire logic            aresetn,
    input  wire logic            ce,
    // AXI4-Lite write address
    input  wire logic            s_axi_awvalid,
    output logic                 s_axi_awready,
    input  wire logic [7:0]      s_axi_awaddr,
    input  wire logic [2:0]      s_axi_awprot,
    // AXI4-Lite write data
    input  wire logic            s_axi_wvalid,
    output logic                 s_axi_wready,
    input  wire logic [31:0]     s_axi_wdata,
    input  wire logic [3:0]      s_axi_wstrb,
    // AXI4-Lite write response
    output logic                 s_axi_bvalid,
    input  wire logic            s_axi_bready,
    output logic [1:0]           s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic            s_axi_arvalid,
    output logic                 s_axi_arready,
    input  wire logic [7:0]      s_axi_araddr,
    input  wire logic [2:0]      s_axi_arprot,
    // AXI4-Lite read data
    output logic                 s_axi_rvalid,
    input  wire logic            s_axi_rready,
    output logic [31:0]          s_axi_rdata,
    output logic [1:0]           s_axi_rresp,
    // Peripheral outputs, same clock
    input  wire logic            numeric_osc_output,
    input  wire logic            logic_cell_one_output,
    input  wire logic            logic_cell_two_output,
    input  wire logic            logic_cell_three_output,
    input  wire logic            logic_cell_four_output,
    input  wire logic            complementary_gen_phase_a,
    input  wire logic            complementary_gen_phase_b,
    input  wire logic            complementary_gen_phase_c,
    input  wire logic            complementary_gen_phase_d,
    input  wire logic            capture_compare_one_output,
    input  wire logic            capture_compare_two_output,
    input  wire logic            pwm_channel_three_output,
    input  wire logic            pwm_channel_four_output,
    input  wire logic            serial_clock_out,
    input  wire logic            serial_data_out,
    input  wire logic            usart_transmit_clock,
    input  wire logic            usart_sync_data,
    input  wire logic            comparator_one_output,
    input  wire logic            comparator_two_output,
    // Port D pins
    input  wire logic [PINS-1:0] pin_in,
    output logic      [PINS-1:0] pin_out,
    output logic      [PINS-1:0] pin_oe
);

    // Register state
    logic [PINS-1:0] port_d_output_latch_ff;
    logic [PINS-1:0] pin_direction_control_ff;
    logic [4:0]      pin_output_source_select_ff [PINS];

    // Write channel state
    logic            aw_held_ff;
    logic [7:0]      aw_addr_ff;
    logic            w_held_ff;
    logic [31:0]     w_data_ff;
    logic            w_lane0_ff;
    logic            bvalid_ff;
    logic [1:0]      bresp_ff;

    // Read channel state
    logic            rvalid_ff;
    logic [31:0]     rdata_ff;
    logic [1:0]      rresp_ff;

    // Decode and selection
    logic            aw_take;
    logic            w_take;
    logic            ar_take;
    logic            do_write;

    logic            wr_latch;
    logic            wr_pins;
    logic            wr_dir;
    logic            wr_sel_any;
    logic            wr_hit;
    logic            wr_lane;
    logic [2:0]      wr_idx;

    logic            rd_latch;
    logic            rd_pins;
    logic            rd_dir;
    logic            rd_sel_any;
    logic            rd_hit;
    logic [2:0]      rd_idx;

    logic [31:0]     rd_word;
    logic [31:0]     nxt_rdata;
    logic [1:0]      nxt_bresp;
    logic [1:0]      nxt_rresp;
    logic [PINS-1:0] nxt_latch;
    logic [PINS-1:0] pin_level;
    logic [31:0]     shared_src;

    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take  = s_axi_wvalid & s_axi_wready;
    assign ar_take = s_axi_arvalid & s_axi_arready;

    // One write in flight; both halves may arrive in either order
    // Clock enable low stalls every handshake, so no beat is lost
    assign s_axi_awready = ce & ~aw_held_ff & ~bvalid_ff;
    assign s_axi_wready  = ce & ~w_held_ff & ~bvalid_ff;
    assign s_axi_arready = ce & ~rvalid_ff;
    assign do_write      = aw_held_ff & w_held_ff & ~bvalid_ff;

    assign wr_latch   = (aw_addr_ff == posm_pkg::POSM_OFS_LATCH);
    assign wr_pins    = (aw_addr_ff == posm_pkg::POSM_OFS_PINS);
    assign wr_dir     = (aw_addr_ff == posm_pkg::POSM_OFS_DIR);
    assign wr_sel_any = (aw_addr_ff >= posm_pkg::POSM_OFS_SEL)
                      & (aw_addr_ff <= posm_pkg::POSM_OFS_SEL_END)
                      & (aw_addr_ff[1:0] == 2'b00);
    assign wr_hit     = wr_latch | wr_pins | wr_dir | wr_sel_any;
    // Selector index is the word within the select block
    assign wr_idx     = aw_addr_ff[posm_pkg::POSM_IDX_MSB:posm_pkg::POSM_IDX_LSB];
    // Registers are eight bits wide, so only lane 0 carries data
    assign wr_lane    = do_write & w_lane0_ff;

    assign rd_latch   = (s_axi_araddr == posm_pkg::POSM_OFS_LATCH);
    assign rd_pins    = (s_axi_araddr == posm_pkg::POSM_OFS_PINS);
    assign rd_dir     = (s_axi_araddr == posm_pkg::POSM_OFS_DIR);
    assign rd_sel_any = (s_axi_araddr >= posm_pkg::POSM_OFS_SEL)
                      & (s_axi_araddr <= posm_pkg::POSM_OFS_SEL_END)
                      & (s_axi_araddr[1:0] == 2'b00);
    assign rd_hit     = rd_latch | rd_pins | rd_dir | rd_sel_any;
    assign rd_idx     = s_axi_araddr[posm_pkg::POSM_IDX_MSB:posm_pkg::POSM_IDX_LSB];

    // Pin register reads see synchronised pin levels, not the latch
    assign rd_word = rd_latch   ? {24'h000000, port_d_output_latch_ff}
                   : rd_pins    ? {24'h000000, pin_level}
                   : rd_dir     ? {24'h000000, pin_direction_control_ff}
                   : rd_sel_any ? {27'h0000000, pin_output_source_select_ff[rd_idx]}
                   : 32'h00000000;
    assign nxt_rdata = rd_word;
    assign nxt_rresp = rd_hit ? posm_pkg::POSM_RESP_OKAY : posm_pkg::POSM_RESP_SLVERR;
    assign nxt_bresp = wr_hit ? posm_pkg::POSM_RESP_OKAY : posm_pkg::POSM_RESP_SLVERR;

    // Both data offsets land in the same latch
    assign nxt_latch = (wr_lane & (wr_latch | wr_pins))
                     ? w_data_ff[PINS-1:0] : port_d_output_latch_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_held_ff  <= 1'b0;
            w_data_ff  <= 32'h00000000;
            w_lane0_ff <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= posm_pkg::POSM_RESP_OKAY;
        end
        else if (ce)
        begin
            if (aw_take)
            begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            else if (do_write)
            begin
                aw_held_ff <= 1'b0;
            end

            if (w_take)
            begin
                w_held_ff  <= 1'b1;
                w_data_ff  <= s_axi_wdata;
                w_lane0_ff <= s_axi_wstrb[0];
            end
            else if (do_write)
            begin
                w_held_ff <= 1'b0;
            end

            // Response rises one cycle after both halves are held
            if (do_write)
            begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= nxt_bresp;
            end
            else if (s_axi_bready)
            begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h00000000;
            rresp_ff  <= posm_pkg::POSM_RESP_OKAY;
        end
        else if (ce)
        begin
            // Read data captured at the address edge, held until taken
            if (ar_take)
            begin
                rvalid_ff <= 1'b1;
                rdata_ff  <= nxt_rdata;
                rresp_ff  <= nxt_rresp;
            end
            else if (s_axi_rready)
            begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // Bus reset stands for power-on; unknown latch content is given a value
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            port_d_output_latch_ff   <= posm_pkg::POSM_LATCH_RST;
            pin_direction_control_ff <= posm_pkg::POSM_DIR_RST;
        end
        else if (ce)
        begin
            port_d_output_latch_ff <= nxt_latch;
            if (wr_lane & wr_dir)
            begin
                pin_direction_control_ff <= w_data_ff[PINS-1:0];
            end
        end
    end

    // Answers hide while frozen, so none is taken twice
    assign s_axi_bvalid = ce & bvalid_ff;
    assign s_axi_bresp  = bresp_ff;
    assign s_axi_rvalid = ce & rvalid_ff;
    assign s_axi_rdata  = rdata_ff;
    assign s_axi_rresp  = rresp_ff;

    // Pins are asynchronous: two flops before any read
    posm_sync2 #(
        .W (PINS)
    ) u_pin_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .ce       (ce),
        .async_in (pin_in),
        .sync_out (pin_level)
    );

    // Common sources; bit 0 is replaced by each pin's own latch bit
    assign shared_src = {
        8'h00,                                  // 11xxx reserved
        comparator_two_output,                  // 10111
        comparator_one_output,                  // 10110
        usart_sync_data,                        // 10101
        usart_transmit_clock,                   // 10100
        2'b00,                                  // 10011, 10010 reserved
        serial_data_out,                        // 10001
        serial_clock_out,                       // 10000
        pwm_channel_four_output,                // 01111
        pwm_channel_three_output,               // 01110
        capture_compare_two_output,             // 01101
        capture_compare_one_output,             // 01100
        complementary_gen_phase_d,              // 01011
        complementary_gen_phase_c,              // 01010
        complementary_gen_phase_b,              // 01001
        complementary_gen_phase_a,              // 01000
        logic_cell_four_output,                 // 00111
        logic_cell_three_output,                // 00110
        logic_cell_two_output,                  // 00101
        logic_cell_one_output,                  // 00100
        numeric_osc_output,                     // 00011
        2'b00,                                  // 00010, 00001 reserved
        1'b0
    };

    genvar gi;

    generate
        for (gi = 0; gi < PINS; gi++)
        begin : g_pin
            logic        sel_we;
            logic [31:0] pin_src;

            // Only the addressed pin's selector takes the write
            assign sel_we  = wr_lane & wr_sel_any & (wr_idx == 3'(gi));
            assign pin_src = {shared_src[31:1], port_d_output_latch_ff[gi]};

            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    pin_output_source_select_ff[gi] <= posm_pkg::POSM_SEL_RST;
                end
                else if (ce && sel_we)
                begin
                    // Upper three bits are not stored
                    pin_output_source_select_ff[gi] <=
                        w_data_ff[posm_pkg::POSM_SEL_MSB:posm_pkg::POSM_SEL_LSB];
                end
            end

            posm_src_mux #(
                .SUPPORT  (SUPPORT),
                .OVERRIDE (OVERRIDE)
            ) u_mux (
                .sel          (pin_output_source_select_ff[gi]),
                .sources      (pin_src),
                .dir_is_input (pin_direction_control_ff[gi]),
                .pin_o        (pin_out[gi]),
                .pin_oe       (pin_oe[gi])
            );
        end
    endgenerate

    // Protection bits carry no meaning for these registers
    logic unused_prot;
    assign unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_wstrb[3:1]};

endmodule : posm_top

// >>> verification/posm_props.sv
// Purpose: Port-level checks of the register bus and reset state.
// Assumes: One aclk domain, synchronous active-low reset.
// Notes:   Pin routing needs register state, so the bench checks it.
`timescale 1ns/1ps
module posm_props #(
    parameter int PINS = 8
) (
    input wire logic            aclk,
    input wire logic            aresetn,
    input wire logic            ce,
    input wire logic            s_axi_awvalid,
    input wire logic            s_axi_awready,
    input wire logic            s_axi_wvalid,
    input wire logic            s_axi_wready,
    input wire logic            s_axi_bvalid,
    input wire logic            s_axi_bready,
    input wire logic [1:0]      s_axi_bresp,
    input wire logic            s_axi_arvalid,
    input wire logic            s_axi_arready,
    input wire logic [7:0]      s_axi_araddr,
    input wire logic            s_axi_rvalid,
    input wire logic            s_axi_rready,
    input wire logic [31:0]     s_axi_rdata,
    input wire logic [1:0]      s_axi_rresp,
    input wire logic [PINS-1:0] pin_oe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence wr_taken;
        ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        ce && s_axi_arvalid && s_axi_arready;
    endsequence

    wr_answer_a: assert property (wr_taken ##1 ce |-> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response not one cycle after both halves");
    rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read data not right after address");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    rvalid_drop_a: assert property (s_axi_rvalid && s_axi_rready && ce |=> !s_axi_rvalid)
        else $error("read data repeated");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken during answer");
    wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during answer");
    byte_wide_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    unmapped_rd_a: assert property (ce && s_axi_arvalid && s_axi_arready
        && s_axi_araddr == 8'h0C |=> s_axi_rresp == posm_pkg::POSM_RESP_SLVERR
        && s_axi_rdata == 32'h00000000) else $error("unmapped read not refused");
    reset_idle_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
        && pin_oe == '0) else $error("state after reset not idle");
endmodule : posm_props

bind posm_top posm_props #(.PINS(PINS)) u_posm_props (
    .aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .pin_oe
);

// >>> verification/tb_top.sv
// Purpose: Self-checking bench for the pin output source multiplexer.
// Assumes: ce dropped once; bus answers waited for, never counted.
// Notes:   Peripheral inputs form one vector indexed by selection code.
`timescale 1ns/1ps
module tb_top;
    localparam logic [31:0] PORT_D_OK = 32'h0040_8EC9;
    localparam logic [31:0] DRV_TAKE  = 32'h0033_0F00;
    logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, pin_in, pin_out, pin_oe, lat_e, dir_e;
    logic [31:0] s_axi_wdata, s_axi_rdata, src, rd;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [4:0]  sel_e [8];
    int          failures, num_checks;

    posm_top u_posm_top (
        .aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .numeric_osc_output(src[3]),
        .logic_cell_one_output(src[4]), .logic_cell_two_output(src[5]),
        .logic_cell_three_output(src[6]), .logic_cell_four_output(src[7]),
        .complementary_gen_phase_a(src[8]), .complementary_gen_phase_b(src[9]),
        .complementary_gen_phase_c(src[10]), .complementary_gen_phase_d(src[11]),
        .capture_compare_one_output(src[12]), .capture_compare_two_output(src[13]),
        .pwm_channel_three_output(src[14]), .pwm_channel_four_output(src[15]),
        .serial_clock_out(src[16]), .serial_data_out(src[17]),
        .usart_transmit_clock(src[20]), .usart_sync_data(src[21]),
        .comparator_one_output(src[22]), .comparator_two_output(src[23]),
        .pin_in, .pin_out, .pin_oe
    );

    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task automatic close_out();
        if (failures == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Valid drops at the edge that takes it; the extra edge parts two calls
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready)
            begin
                r = s_axi_bresp;
                break;
            end
        end
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready)
            begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                break;
            end
        end
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_rd

    task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
        axi_wr(a, d, resp);
        chk({30'h0, resp}, {30'h0, posm_pkg::POSM_RESP_OKAY});
    endtask : wr_ok

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        axi_rd(a, rd, resp);
        chk(rd, exp);
        chk({30'h0, resp}, {30'h0, posm_pkg::POSM_RESP_OKAY});
    endtask : rd_chk

    task automatic pin_chk();
        logic [7:0] eo, ee;
        logic [4:0] c;
        @(negedge aclk);
        for (int p = 0; p < 8; p++)
        begin
            c     = sel_e[p];
            eo[p] = PORT_D_OK[c] && ((c == 5'h00) ? lat_e[p] : src[c]);
            ee[p] = (PORT_D_OK[c] && DRV_TAKE[c]) ? 1'b1 : !dir_e[p];
        end
        chk({24'h0, pin_out}, {24'h0, eo});
        chk({24'h0, pin_oe}, {24'h0, ee});
        @(posedge aclk);
    endtask : pin_chk

    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {src, pin_in, failures, num_checks} = '0;
        ce    = 1'b1;
        lat_e = 8'h00;
        dir_e = 8'hFF;
        foreach (sel_e[i]) sel_e[i] = 5'h00;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int p = 0; p < 8; p++) rd_chk(8'(8'h20 + 4 * p), 32'h0);
        pin_chk();
        wr_ok(8'h00, 32'hFFFF_FFA5);
        rd_chk(8'h00, 32'h0000_00A5);
        wr_ok(8'h04, 32'h0000_005A);
        lat_e = 8'h5A;
        rd_chk(8'h00, 32'h0000_005A);
        pin_in <= 8'h96;
        repeat (3) @(posedge aclk);
        rd_chk(8'h04, 32'h0000_0096);
        wr_ok(8'h08, 32'h0000_000F);
        dir_e = 8'h0F;
        pin_chk();
        wr_ok(8'h20, 32'h0000_00FF);
        sel_e[0] = 5'h1F;
        rd_chk(8'h20, 32'h0000_001F);
        // Walk every code over the pins; one-hot then one-cold sources
        for (int c = 0; c < 32; c++)
        begin
            wr_ok(8'(8'h20 + 4 * (c % 8)), 32'(c));
            sel_e[c % 8] = 5'(c);
            pin_chk();
            src <= 32'h1 << c;
            pin_chk();
            src <= ~(32'h1 << c);
            pin_chk();
        end
        axi_wr(8'h0C, 32'h0000_0001, resp);
        chk({30'h0, resp}, {30'h0, posm_pkg::POSM_RESP_SLVERR});
        axi_rd(8'h21, rd, resp);
        chk({30'h0, resp}, {30'h0, posm_pkg::POSM_RESP_SLVERR});
        axi_rd(8'h0C, rd, resp);
        chk(rd, 32'h0);
        // Frozen clock enable must hold the pin synchroniser still
        ce     <= 1'b0;
        pin_in <= 8'h3C;
        repeat (4) @(posedge aclk);
        ce <= 1'b1;
        rd_chk(8'h04, 32'h0000_0096);
        // Reset in mid-run must clear every selection
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        lat_e = 8'h00;
        dir_e = 8'hFF;
        foreach (sel_e[i]) sel_e[i] = 5'h00;
        pin_chk();
        rd_chk(8'h3C, 32'h0);
        close_out();
    end

    // Whole run is well under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge aclk);
        failures++;
        close_out();
    end
endmodule : tb_top
